//--- csbm_assertions.sv
// assertion checker for the clock supply and boot monitor
`timescale 1ns/1ps
`default_nettype none
module csbm_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus responses
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // boot routine
    input wire logic bcrRunning,
    input wire logic bootCfgIntegrityErr,
    input wire logic trimIntegrityErr,
    input wire logic bootReset,
    // brownout warning
    input wire logic brownoutWarnEnable,
    input wire logic brownoutResetMode,
    input wire logic nmiEvent
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ========================================
    // boot retry
    sequence sBootFail;
        bcrRunning && !bootReset && (bootCfgIntegrityErr || trimIntegrityErr);
    endsequence
    sequence sBootHold;
        bootReset [*8];
    endsequence
    AST_BOOT_ON_ERR: assert property (sBootFail |=> sBootHold)
        else $error("boot reset missing after boot error");
    AST_BOOT_CAUSE: assert property ($rose(bootReset) |-> $past(bcrRunning))
        else $error("boot reset without running boot routine");
    AST_BOOT_MIN: assert property ($fell(bootReset) |-> $past(bootReset, 8))
        else $error("boot reset too short");
    // ========================================
    // brownout warning
    AST_NMI_PULSE: assert property (nmiEvent |=> !nmiEvent)
        else $error("nmi event longer than one cycle");
    AST_NMI_MODE: assert property (nmiEvent |-> ##[0:1] brownoutResetMode)
        else $error("reset mode not set after warning");
    AST_MODE_STICKY: assert property (brownoutResetMode |=> brownoutResetMode)
        else $error("reset mode dropped");
    AST_NMI_ENABLED: assert property (nmiEvent |-> $past(brownoutWarnEnable))
        else $error("nmi event with warning disabled");
    AST_NMI_ONCE: assert property (nmiEvent |-> !$past(brownoutResetMode))
        else $error("second nmi event");
    // ========================================
    // bus responses hold
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
endmodule // csbm_checker
bind csbm_top csbm_checker i_chk (.*);
`default_nettype wire

//--- csbm_defines.vh
// constants for the clock supply and boot monitor
`ifndef CSBM_DEFINES_VH
`define CSBM_DEFINES_VH
// ========================================
// register byte offsets
`define CSBM_ADDR_CTRL 8'h00
`define CSBM_ADDR_STATUS 8'h04
`define CSBM_ADDR_FCC_COUNT 8'h08
`define CSBM_ADDR_INT_STAT 8'h0C
`define CSBM_ADDR_INT_MASK 8'h10
`define CSBM_ADDR_BOOT_STAT 8'h14
// ========================================
// control fields
`define CSBM_CTRL_PLL_EN 0
`define CSBM_CTRL_LF_EXT 1
`define CSBM_CTRL_FCC_START 2
`define CSBM_CTRL_WARN_EN 3
`define CSBM_CTRL_FCC_SRC 4
`define CSBM_CTRL_WARN_LVL_LSB 8
`define CSBM_CTRL_WARN_LVL_MSB 10
`define CSBM_CTRL_WMASK 32'h0000071B
// ========================================
// status fields
`define CSBM_ST_LF_STUCK 0
`define CSBM_ST_PLL_GOOD 1
`define CSBM_ST_PLL_DEAD 2
`define CSBM_ST_BROWNOUT 3
`define CSBM_ST_FCC_DONE 4
`define CSBM_ST_BOR_RST_MODE 5
`define CSBM_ST_FCC_BUSY 6
// ========================================
// interrupt fields
`define CSBM_INT_LF_STUCK 0
`define CSBM_INT_PLL_GOOD 1
`define CSBM_INT_PLL_DEAD 2
`define CSBM_INT_FCC_DONE 3
`define CSBM_INT_BOOT_FAIL 4
`define CSBM_INT_WARN 5
`define CSBM_INT_WIDTH 6
// ========================================
// reset values
`define CSBM_CTRL_RESET 32'h00000000
`define CSBM_INT_MASK_RESET 6'h00
// ========================================
// bus responses
`define CSBM_RESP_OKAY 2'h0
`define CSBM_RESP_SLVERR 2'h2
// ========================================
// timing
`define CSBM_CLK_PERIOD_NS 10
`define CSBM_PLL_SETTLE_NS 10000
`define CSBM_LF_STUCK_NS 100000
`define CSBM_BCR_TIMEOUT_NS 1000000
`define CSBM_BOOT_RST_NS 1000
`define CSBM_PLL_SETTLE_CYCLES ((`CSBM_PLL_SETTLE_NS + `CSBM_CLK_PERIOD_NS - 1) / `CSBM_CLK_PERIOD_NS)
`define CSBM_LF_STUCK_CYCLES ((`CSBM_LF_STUCK_NS + `CSBM_CLK_PERIOD_NS - 1) / `CSBM_CLK_PERIOD_NS)
`define CSBM_BCR_TIMEOUT_CYCLES ((`CSBM_BCR_TIMEOUT_NS + `CSBM_CLK_PERIOD_NS - 1) / `CSBM_CLK_PERIOD_NS)
`define CSBM_BOOT_RST_CYCLES ((`CSBM_BOOT_RST_NS + `CSBM_CLK_PERIOD_NS - 1) / `CSBM_CLK_PERIOD_NS)
`define CSBM_FCC_REF_PERIODS 32
`endif

//--- csbm_sync.v
// two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module csbm_sync #(
    parameter WIDTH = 6
) (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // asynchronous in, synchronous out
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    // ========================================
    // per-bit flop pair
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    meta_q <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= asyncIn[i];
                    stable_q <= meta_q;
                end
            end
            assign syncOut[i] = stable_q;
        end
    endgenerate
endmodule // csbm_sync
`default_nettype wire

//--- csbm_tb.sv
// self-checking testbench for the clock supply and boot monitor
`timescale 1ns/1ps
`default_nettype none
`include "csbm_defines.vh"
module testbench;
    logic mclk = 0, resetn = 0, lfRun = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic lowFreqClockIn = 0, systemPllClockIn = 0, refClockIn = 0, systemPllLock = 0;
    logic brownoutViolation = 0, brownoutWarnTrip = 0;
    logic bcrRunning = 0, bootCfgIntegrityErr = 0, trimIntegrityErr = 0;
    logic [2:0] lvl;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire systemPllEnable, brownoutWarnEnable, brownoutResetMode, bootReset, nmiEvent, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0] brownoutWarnLevel;
    int num_errors = 0, checks_done = 0, cycles = 0, n, k;
    localparam int FCC_EXP = 4 * 16 / 8;
    csbm_top #(.LF_STUCK_CYCLES(32'd20), .BCR_TIMEOUT_CYCLES(32'd50), .FCC_REF_PERIODS(32'd4)) i_dut (.*);
    // ========================================
    // clock, monitored clocks, timeout
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (lfRun && cycles % 4 == 3) lowFreqClockIn <= ~lowFreqClockIn;
        if (cycles % 8 == 7) refClockIn <= ~refClockIn;
        if (cycles == 30000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ========================================
    // helpers
    function automatic [31:0] expCtrl(input [31:0] d);
        return d & `CSBM_CTRL_WMASK & ~32'h00000004;
    endfunction
    task automatic chk(input [31:0] seen, input [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= $urandom % 2;
        forever begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid && s_axi_bready) break;
            if ($urandom % 2) s_axi_bready <= 1;
        end
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rchk(input [7:0] a, input [31:0] m, input [31:0] exp);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= $urandom % 2;
        forever begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid && s_axi_rready) break;
            if ($urandom % 2) s_axi_rready <= 1;
        end
        v = s_axi_rdata;
        chk(s_axi_rresp, (a > 8'h14 || a[1:0] != 2'h0) ? `CSBM_RESP_SLVERR : `CSBM_RESP_OKAY);
        s_axi_rready <= 0;
        chk(v & m, exp);
    endtask
    // ========================================
    // main sequence
    initial begin
        void'($urandom(32'h6E709FE4));
        repeat (20) @(posedge mclk);
        resetn <= 1;
        repeat (4) @(posedge mclk);
        rchk(`CSBM_ADDR_CTRL, 32'hFFFFFFFF, `CSBM_CTRL_RESET);
        rchk(`CSBM_ADDR_INT_MASK, 32'h3F, 32'h0);
        wr(8'h18, 32'h0, `CSBM_RESP_SLVERR);
        rchk(8'h18, 32'hFFFFFFFF, 32'h0);
        wr(`CSBM_ADDR_STATUS, 32'h0, `CSBM_RESP_SLVERR);
        repeat (4) begin
            v = $urandom & 32'h00000714;
            wr(`CSBM_ADDR_CTRL, v, `CSBM_RESP_OKAY);
            chk(brownoutWarnLevel, v[10:8]);
            rchk(`CSBM_ADDR_CTRL, 32'hFFFFFFFF, expCtrl(v));
        end
        systemPllLock <= 1;
        wr(`CSBM_ADDR_CTRL, 32'h1, `CSBM_RESP_OKAY);
        chk(systemPllEnable, 1);
        repeat (1010) @(posedge mclk);
        rchk(`CSBM_ADDR_STATUS, 32'h6, 32'h2);
        rchk(`CSBM_ADDR_INT_STAT, 32'h2, 32'h2);
        systemPllLock <= 0;
        wr(`CSBM_ADDR_CTRL, 32'h0, `CSBM_RESP_OKAY);
        rchk(`CSBM_ADDR_STATUS, 32'h6, 32'h2);
        wr(`CSBM_ADDR_CTRL, 32'h1, `CSBM_RESP_OKAY);
        rchk(`CSBM_ADDR_STATUS, 32'h6, 32'h0);
        repeat (1010) @(posedge mclk);
        rchk(`CSBM_ADDR_STATUS, 32'h6, 32'h4);
        wr(`CSBM_ADDR_INT_MASK, 32'h4, `CSBM_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 1);
        wr(`CSBM_ADDR_INT_STAT, 32'h6, `CSBM_RESP_OKAY);
        repeat (2) @(posedge mclk);
        chk(irq, 0);
        rchk(`CSBM_ADDR_INT_STAT, 32'h6, 32'h0);
        brownoutViolation <= 1;
        repeat (5) @(posedge mclk);
        rchk(`CSBM_ADDR_STATUS, 32'h8, 32'h8);
        brownoutViolation <= 0;
        repeat (5) @(posedge mclk);
        rchk(`CSBM_ADDR_STATUS, 32'h8, 32'h0);
        lfRun <= 1;
        wr(`CSBM_ADDR_CTRL, 32'h4, `CSBM_RESP_OKAY);
        repeat (120) @(posedge mclk);
        rchk(`CSBM_ADDR_FCC_COUNT, 32'hFFFFFFF0, 32'h0);
        chk(v - (FCC_EXP - 1) <= 2, 1);
        wr(`CSBM_ADDR_CTRL, 32'h2, `CSBM_RESP_OKAY);
        repeat (40) @(posedge mclk);
        rchk(`CSBM_ADDR_STATUS, 32'h1, 32'h0);
        lfRun <= 0;
        repeat (40) @(posedge mclk);
        rchk(`CSBM_ADDR_STATUS, 32'h1, 32'h1);
        for (k = 0; k < 3; k++) begin
            bcrRunning <= 1;
            bootCfgIntegrityErr <= (k == 0);
            trimIntegrityErr <= (k == 1);
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (bootReset !== 1 && n < 200);
            bcrRunning <= 0;
            bootCfgIntegrityErr <= 0;
            trimIntegrityErr <= 0;
            chk(k == 2 ? (n >= 50 && n <= 54) : (n <= 4), 1);
            repeat (110) @(posedge mclk);
            rchk(`CSBM_ADDR_BOOT_STAT, 32'hFFFF, k + 1);
        end
        lvl = $urandom;
        wr(`CSBM_ADDR_CTRL, {21'h0, lvl, 8'h08}, `CSBM_RESP_OKAY);
        chk(brownoutWarnLevel, lvl);
        chk(brownoutWarnEnable, 1);
        brownoutWarnTrip <= 1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (nmiEvent !== 1 && n < 20);
        chk(nmiEvent, 1);
        repeat (2) @(posedge mclk);
        chk(brownoutResetMode, 1);
        rchk(`CSBM_ADDR_INT_STAT, 32'h20, 32'h20);
        resetn <= 0;
        repeat (2) @(posedge mclk);
        resetn <= 1;
        repeat (4) @(posedge mclk);
        chk(brownoutResetMode, 0);
        rchk(`CSBM_ADDR_INT_STAT, 32'h3F, 32'h0);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire

//--- csbm_top.v
// clock supply and boot monitor with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "csbm_defines.vh"
module csbm_top #(
    parameter [31:0] LF_STUCK_CYCLES = `CSBM_LF_STUCK_CYCLES,
    parameter [31:0] BCR_TIMEOUT_CYCLES = `CSBM_BCR_TIMEOUT_CYCLES,
    parameter [31:0] FCC_REF_PERIODS = `CSBM_FCC_REF_PERIODS
) (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // asynchronous monitored signals
    input wire lowFreqClockIn,
    input wire systemPllClockIn,
    input wire refClockIn,
    input wire systemPllLock,
    input wire brownoutViolation,
    input wire brownoutWarnTrip,
    // boot routine status
    input wire bcrRunning,
    input wire bootCfgIntegrityErr,
    input wire trimIntegrityErr,
    // controls out
    output wire systemPllEnable,
    output wire brownoutWarnEnable,
    output wire [2:0] brownoutWarnLevel,
    output wire brownoutResetMode,
    output wire bootReset,
    output wire nmiEvent,
    output wire irq
);
    // ========================================
    // local constants
    localparam [31:0] PLL_SETTLE_CYCLES = `CSBM_PLL_SETTLE_CYCLES;
    localparam [31:0] BOOT_RST_CYCLES = `CSBM_BOOT_RST_CYCLES;
    localparam [2:0] PLL_IDLE = 3'h1;
    localparam [2:0] PLL_WAIT = 3'h2;
    localparam [2:0] PLL_DONE = 3'h4;
    localparam [2:0] FCC_IDLE = 3'h1;
    localparam [2:0] FCC_ARM = 3'h2;
    localparam [2:0] FCC_COUNT = 3'h4;
    // ========================================
    // synchronised inputs
    wire [5:0] syncIn;
    csbm_sync #(
        .WIDTH(6)
    ) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn({brownoutWarnTrip, brownoutViolation, systemPllLock,
                  refClockIn, systemPllClockIn, lowFreqClockIn}),
        .syncOut(syncIn)
    );
    reg [5:0] syncDly_q;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncDly_q <= 6'h00;
        end else begin
            syncDly_q <= syncIn;
        end
    end
    wire lfEdge = syncIn[0] ^ syncDly_q[0];
    wire pllRise = syncIn[1] & ~syncDly_q[1];
    wire refRise = syncIn[2] & ~syncDly_q[2];
    wire pllLocked = syncIn[3];
    wire borLevel = syncIn[4];
    wire warnRise = syncIn[5] & ~syncDly_q[5];
    // ========================================
    // axi4-lite slave
    reg awHave_q;
    reg wHave_q;
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    reg bValid_q;
    reg [1:0] bResp_q;
    reg rValid_q;
    reg [1:0] rResp_q;
    reg [31:0] rData_q;
    reg [31:0] ctrl_q;
    reg [`CSBM_INT_WIDTH-1:0] intStat_q;
    reg [`CSBM_INT_WIDTH-1:0] intMask_q;
    reg [31:0] rdMux;
    reg rdHit;
    wire awTake = s_axi_awvalid & s_axi_awready;
    wire wTake = s_axi_wvalid & s_axi_wready;
    wire arTake = s_axi_arvalid & s_axi_arready;
    wire wrGo = awHave_q & wHave_q & ~bValid_q;
    wire [31:0] byteMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    wire wrCtrl = wrGo & (awAddr_q == `CSBM_ADDR_CTRL);
    wire wrIntStat = wrGo & (awAddr_q == `CSBM_ADDR_INT_STAT);
    wire wrIntMask = wrGo & (awAddr_q == `CSBM_ADDR_INT_MASK);
    wire wrHit = wrCtrl | wrIntStat | wrIntMask;
    wire [31:0] ctrlNew = (ctrl_q & ~(byteMask & `CSBM_CTRL_WMASK)) |
                          (wData_q & byteMask & `CSBM_CTRL_WMASK);
    wire fccStart = wrCtrl & wStrb_q[0] & wData_q[`CSBM_CTRL_FCC_START];
    assign s_axi_awready = ~awHave_q & ~bValid_q;
    assign s_axi_wready = ~wHave_q & ~bValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = ~rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rresp = rResp_q;
    assign s_axi_rdata = rData_q;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            bValid_q <= 1'b0;
            bResp_q <= `CSBM_RESP_OKAY;
            rValid_q <= 1'b0;
            rResp_q <= `CSBM_RESP_OKAY;
            rData_q <= 32'h00000000;
        end else begin
            if (awTake) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (wTake) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrGo) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                bValid_q <= 1'b1;
                bResp_q <= wrHit ? `CSBM_RESP_OKAY : `CSBM_RESP_SLVERR;
            end else if (bValid_q && s_axi_bready) begin
                bValid_q <= 1'b0;
            end
            if (arTake) begin
                rValid_q <= 1'b1;
                rData_q <= rdMux;
                rResp_q <= rdHit ? `CSBM_RESP_OKAY : `CSBM_RESP_SLVERR;
            end else if (rValid_q && s_axi_rready) begin
                rValid_q <= 1'b0;
            end
        end
    end
    // ========================================
    // control register
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `CSBM_CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_q <= ctrlNew & ~(32'h00000001 << `CSBM_CTRL_FCC_START);
        end
    end
    assign systemPllEnable = ctrl_q[`CSBM_CTRL_PLL_EN];
    assign brownoutWarnEnable = ctrl_q[`CSBM_CTRL_WARN_EN];
    assign brownoutWarnLevel = ctrl_q[`CSBM_CTRL_WARN_LVL_MSB:`CSBM_CTRL_WARN_LVL_LSB];
    wire pllStart = wrCtrl & ~ctrl_q[`CSBM_CTRL_PLL_EN] & ctrlNew[`CSBM_CTRL_PLL_EN];
    // ========================================
    // low-frequency clock stuck monitor
    reg [31:0] lfCnt_q;
    reg lfStuck_q;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lfCnt_q <= 32'h00000000;
            lfStuck_q <= 1'b0;
        end else if (!ctrl_q[`CSBM_CTRL_LF_EXT]) begin
            lfCnt_q <= 32'h00000000;
            lfStuck_q <= 1'b0;
        end else if (lfEdge) begin
            lfCnt_q <= 32'h00000000;
            lfStuck_q <= 1'b0;
        end else if (lfCnt_q >= LF_STUCK_CYCLES - 32'h00000001) begin
            lfStuck_q <= 1'b1;
        end else begin
            lfCnt_q <= lfCnt_q + 32'h00000001;
        end
    end
    wire lfStuckSet = ctrl_q[`CSBM_CTRL_LF_EXT] & ~lfEdge & ~lfStuck_q &
                      (lfCnt_q >= LF_STUCK_CYCLES - 32'h00000001);
    // ========================================
    // system pll start-up monitor
    reg [2:0] pllState_q;
    reg [31:0] pllCnt_q;
    reg pllGood_q;
    reg pllDead_q;
    reg pllGoodSet;
    reg pllDeadSet;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pllState_q <= PLL_IDLE;
            pllCnt_q <= 32'h00000000;
            pllGood_q <= 1'b0;
            pllDead_q <= 1'b0;
            pllGoodSet <= 1'b0;
            pllDeadSet <= 1'b0;
        end else begin
            pllGoodSet <= 1'b0;
            pllDeadSet <= 1'b0;
            if (pllStart) begin
                pllState_q <= PLL_WAIT;
                pllCnt_q <= 32'h00000000;
                pllGood_q <= 1'b0;
                pllDead_q <= 1'b0;
            end else begin
                case (pllState_q)
                    PLL_IDLE: begin
                        pllCnt_q <= 32'h00000000;
                    end
                    PLL_WAIT: begin
                        if (!ctrl_q[`CSBM_CTRL_PLL_EN]) begin
                            pllState_q <= PLL_IDLE;
                        end else if (pllCnt_q >= PLL_SETTLE_CYCLES - 32'h00000001) begin
                            pllState_q <= PLL_DONE;
                            pllGood_q <= pllLocked;
                            pllDead_q <= ~pllLocked;
                            pllGoodSet <= pllLocked;
                            pllDeadSet <= ~pllLocked;
                        end else begin
                            pllCnt_q <= pllCnt_q + 32'h00000001;
                        end
                    end
                    PLL_DONE: begin
                        if (!ctrl_q[`CSBM_CTRL_PLL_EN]) begin
                            pllState_q <= PLL_IDLE;
                        end
                    end
                    default: begin
                        pllState_q <= PLL_IDLE;
                    end
                endcase
            end
        end
    end
    // ========================================
    // frequency clock counter
    reg [2:0] fccState_q;
    reg [31:0] fccRefCnt_q;
    reg [31:0] fccCnt_q;
    reg [31:0] fccResult_q;
    reg fccDone_q;
    reg fccDoneSet;
    wire srcRise = ctrl_q[`CSBM_CTRL_FCC_SRC] ? pllRise : (syncIn[0] & ~syncDly_q[0]);
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fccState_q <= FCC_IDLE;
            fccRefCnt_q <= 32'h00000000;
            fccCnt_q <= 32'h00000000;
            fccResult_q <= 32'h00000000;
            fccDone_q <= 1'b0;
            fccDoneSet <= 1'b0;
        end else begin
            fccDoneSet <= 1'b0;
            case (fccState_q)
                FCC_IDLE: begin
                    if (fccStart) begin
                        fccState_q <= FCC_ARM;
                        fccDone_q <= 1'b0;
                    end
                end
                FCC_ARM: begin
                    if (refRise) begin
                        fccState_q <= FCC_COUNT;
                        fccRefCnt_q <= 32'h00000000;
                        fccCnt_q <= 32'h00000000;
                    end
                end
                FCC_COUNT: begin
                    if (refRise && fccRefCnt_q >= FCC_REF_PERIODS - 32'h00000001) begin
                        fccState_q <= FCC_IDLE;
                        fccResult_q <= fccCnt_q + {31'h00000000, srcRise};
                        fccDone_q <= 1'b1;
                        fccDoneSet <= 1'b1;
                    end else begin
                        if (refRise) begin
                            fccRefCnt_q <= fccRefCnt_q + 32'h00000001;
                        end
                        if (srcRise) begin
                            fccCnt_q <= fccCnt_q + 32'h00000001;
                        end
                    end
                end
                default: begin
                    fccState_q <= FCC_IDLE;
                end
            endcase
        end
    end
    // ========================================
    // boot process monitor
    reg [31:0] bcrCnt_q;
    reg [31:0] bootRstCnt_q;
    reg bootReset_q;
    reg [15:0] bootFailCnt_q;
    wire bcrTimeout = bcrCnt_q >= BCR_TIMEOUT_CYCLES - 32'h00000001;
    wire bootFail = bcrRunning & ~bootReset_q &
                    (bootCfgIntegrityErr | trimIntegrityErr | bcrTimeout);
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bcrCnt_q <= 32'h00000000;
            bootRstCnt_q <= 32'h00000000;
            bootReset_q <= 1'b0;
            bootFailCnt_q <= 16'h0000;
        end else begin
            if (!bcrRunning || bootReset_q) begin
                bcrCnt_q <= 32'h00000000;
            end else if (!bcrTimeout) begin
                bcrCnt_q <= bcrCnt_q + 32'h00000001;
            end
            if (bootFail) begin
                bootReset_q <= 1'b1;
                bootRstCnt_q <= 32'h00000000;
                bootFailCnt_q <= bootFailCnt_q + 16'h0001;
            end else if (bootReset_q) begin
                if (bootRstCnt_q >= BOOT_RST_CYCLES - 32'h00000001) begin
                    bootReset_q <= 1'b0;
                end else begin
                    bootRstCnt_q <= bootRstCnt_q + 32'h00000001;
                end
            end
        end
    end
    assign bootReset = bootReset_q;
    // ========================================
    // brownout warning monitor
    reg nmi_q;
    reg borResetMode_q;
    wire warnTripEvt = warnRise & ctrl_q[`CSBM_CTRL_WARN_EN] & ~borResetMode_q;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            nmi_q <= 1'b0;
            borResetMode_q <= 1'b0;
        end else begin
            nmi_q <= warnTripEvt;
            if (warnTripEvt) begin
                borResetMode_q <= 1'b1;
            end
        end
    end
    assign nmiEvent = nmi_q;
    assign brownoutResetMode = borResetMode_q;
    // ========================================
    // interrupt status, mask and output
    reg irq_q;
    wire [`CSBM_INT_WIDTH-1:0] intSet = {warnTripEvt, bootFail, fccDoneSet,
                                        pllDeadSet, pllGoodSet, lfStuckSet};
    wire [`CSBM_INT_WIDTH-1:0] intClr = (wrIntStat && wStrb_q[0]) ?
                                       wData_q[`CSBM_INT_WIDTH-1:0] : 6'h00;
    wire [`CSBM_INT_WIDTH-1:0] intStat_d = (intStat_q & ~intClr) | intSet;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            intStat_q <= 6'h00;
            intMask_q <= `CSBM_INT_MASK_RESET;
            irq_q <= 1'b0;
        end else begin
            intStat_q <= intStat_d;
            if (wrIntMask && wStrb_q[0]) begin
                intMask_q <= wData_q[`CSBM_INT_WIDTH-1:0];
            end
            irq_q <= |(intStat_d & intMask_q);
        end
    end
    assign irq = irq_q;
    // ========================================
    // read multiplexer
    always @* begin
        rdMux = 32'h00000000;
        rdHit = 1'b1;
        case (s_axi_araddr)
            `CSBM_ADDR_CTRL: rdMux = ctrl_q;
            `CSBM_ADDR_STATUS: begin
                rdMux[`CSBM_ST_LF_STUCK] = lfStuck_q;
                rdMux[`CSBM_ST_PLL_GOOD] = pllGood_q;
                rdMux[`CSBM_ST_PLL_DEAD] = pllDead_q;
                rdMux[`CSBM_ST_BROWNOUT] = borLevel;
                rdMux[`CSBM_ST_FCC_DONE] = fccDone_q;
                rdMux[`CSBM_ST_BOR_RST_MODE] = borResetMode_q;
                rdMux[`CSBM_ST_FCC_BUSY] = ~fccState_q[0];
            end
            `CSBM_ADDR_FCC_COUNT: rdMux = fccResult_q;
            `CSBM_ADDR_INT_STAT: rdMux = {26'h0000000, intStat_q};
            `CSBM_ADDR_INT_MASK: rdMux = {26'h0000000, intMask_q};
            `CSBM_ADDR_BOOT_STAT: rdMux = {16'h0000, bootFailCnt_q};
            default: rdHit = 1'b0;
        endcase
    end
endmodule // csbm_top
`default_nettype wire
